// File: bench/tb_top.sv
// self-checking bench of the i2c interrupt mask stage, with a bench model
// assumes i2im_top answers apb with zero wait states and raw flags set one edge on
`timescale 1ns/10ps
`include "i2im_defs.svh"

`define TB_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_top;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] raw_event, mask_m, flags_m;
  logic [15:0] lfsr;
  logic er;
  int failures, n_compared;

  ////////////////////////////////////////////////////////////////////////////
  i2im_top i2im_top_i (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_event(raw_event), .irq(irq));

  // clock generation, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer; the idle edge first keeps back-to-back calls race free
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) failures++;
  endtask

  // one cycle of event pulses; flags are set at the following edge
  task automatic ev(input logic [12:0] e);
    @(posedge sys_clk);
    raw_event <= e;
    @(posedge sys_clk);
    raw_event <= 13'h0000;
    flags_m = flags_m | e;
  endtask

  // raw, masked and irq against the model
  task automatic chk_all;
    apb(1'b0, `I2IM_OFF_RAW, 32'h0);
    `TB_CHK(rd, {19'h0, flags_m})
    apb(1'b0, `I2IM_OFF_MASKED, 32'h0);
    `TB_CHK(rd, {19'h0, flags_m & mask_m})
    `TB_CHK(irq, |(flags_m & mask_m))
  endtask

  task automatic wr_mask(input logic [31:0] d);
    apb(1'b1, `I2IM_OFF_MASK, d);
    mask_m = d[12:0];
  endtask

  // reset values of the enable mask, checked field by field
  task automatic chk_reset;
    apb(1'b0, `I2IM_OFF_MASK, 32'h0);
    `TB_CHK(rd[12], 1'b0)
    `TB_CHK(rd[11], 1'b1)
    `TB_CHK(rd[10:8], 3'h0)
    `TB_CHK(rd[7:5], 3'h7)
    `TB_CHK(rd[4:2], 3'h7)
    `TB_CHK(rd[1:0], 2'h3)
    `TB_CHK(rd[31:13], 19'h0)
    chk_all;
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    close_out;
  end

  // main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    raw_event = 13'h0000;
    lfsr = 16'ha1ee;
    mask_m = `I2IM_MASK_RST;
    flags_m = 13'h0000;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    chk_reset;
    // reset-enabled sources raise irq, reset-masked ones stay quiet
    ev(13'h1fff);
    chk_all;
    $display("test reset_values done");
    // each bit gates only its own position
    for (int i = 0; i < 13; i++) begin
      apb(1'b0, `I2IM_OFF_CLR_ALL, 32'h0);
      flags_m = 13'h0000;
      ev(13'h0001 << i);
      wr_mask(32'hffff_ffff ^ (32'h1 << i));
      chk_all;
      wr_mask(32'h1 << i);
      chk_all;
      apb(1'b0, 12'(`I2IM_OFF_CLR_BASE + 4 * i), 32'h0);
      `TB_CHK(rd, 32'h1)
      flags_m[i] = 1'b0;
      chk_all;
    end
    $display("test bit_walk done");
    // random masks, events and write-one-to-clear
    repeat (16) begin
      lfsr = lfsr_next(lfsr);
      wr_mask({lfsr, lfsr_next(lfsr)});
      apb(1'b0, `I2IM_OFF_MASK, 32'h0);
      `TB_CHK(rd, {19'h0, mask_m})
      lfsr = lfsr_next(lfsr);
      ev(lfsr[12:0]);
      chk_all;
      lfsr = lfsr_next(lfsr);
      apb(1'b1, `I2IM_OFF_W1C, {19'h0, lfsr[12:0]});
      flags_m = flags_m & ~lfsr[12:0];
      chk_all;
    end
    $display("test random done");
    // refused and ignored accesses
    apb(1'b1, 12'h100, 32'hffff_ffff);
    `TB_CHK(er, 1'b1)
    apb(1'b0, 12'h031, 32'h0);
    `TB_CHK({er, rd}, 33'h1_0000_0000)
    apb(1'b1, `I2IM_OFF_RAW, 32'h0);
    apb(1'b1, `I2IM_OFF_MASKED, 32'h0);
    `TB_CHK(er, 1'b0)
    chk_all;
    ev(13'h1fff);
    apb(1'b0, `I2IM_OFF_CLR_ALL, 32'h0);
    `TB_CHK(rd, 32'h1)
    flags_m = 13'h0000;
    chk_all;
    $display("test refusals done");
    // second reset in mid-run restores the mask and drops flags
    ev(13'h1fff);
    wr_mask(32'h1fff);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    mask_m = `I2IM_MASK_RST;
    flags_m = 13'h0000;
    chk_reset;
    $display("test second_reset done");
    close_out;
  end
endmodule

// File: src/i2im_defs.svh
// constants of the i2c interrupt mask stage: offsets, bit positions, resets
// assumes a 32-bit apb slave with a 12-bit byte address
//
// Overview of operation
// RQ1 - mask bit one passes its source, zero suppresses it from masked status.
// RQ2 - mask register at 0x30, each bit gates masked status at same position.
// RQ3 - bit 12 masks restart seen, read-write, resets to zero.
// RQ4 - bit 11 masks general call, read-write, resets to one.
// RQ5 - bits 10, 9, 8 mask start, stop, activity; reset to zero.
// RQ6 - bits 7, 6, 5 mask receive done, transmit abort, read request; reset one.
// RQ7 - bits 4, 3, 2 mask transmit empty, transmit overflow, receive full; reset one.
// RQ8 - bits 1, 0 mask receive overflow and receive underflow; reset to one.
// RQ9 - bits 31 to 13 of the mask are reserved, stateless, read zero.
// RQ10 - masked status at 0x2c is raw gated by mask; cleared by clear-register read.
// RQ11 - raw status at 0x34 shows every source regardless of the mask.
// RQ12 - one combined interrupt output, high while any masked status bit is set.
`ifndef I2IM_DEFS_SVH
`define I2IM_DEFS_SVH

`define I2IM_NSRC 13
`define I2IM_AW 12

// register byte offsets
`define I2IM_OFF_MASKED 12'h02c
`define I2IM_OFF_MASK 12'h030
`define I2IM_OFF_RAW 12'h034
`define I2IM_OFF_W1C 12'h038
`define I2IM_OFF_CLR_ALL 12'h03c
`define I2IM_OFF_CLR_BASE 12'h040
`define I2IM_OFF_CLR_LAST 12'h070

// source bit positions
`define I2IM_BIT_RESTART 12
`define I2IM_BIT_GEN_CALL 11
`define I2IM_BIT_START 10
`define I2IM_BIT_STOP 9
`define I2IM_BIT_ACTIVITY 8
`define I2IM_BIT_RX_DONE 7
`define I2IM_BIT_TX_ABRT 6
`define I2IM_BIT_RD_REQ 5
`define I2IM_BIT_TX_EMPTY 4
`define I2IM_BIT_TX_OVER 3
`define I2IM_BIT_RX_FULL 2
`define I2IM_BIT_RX_OVER 1
`define I2IM_BIT_RX_UNDER 0

// reset value of the enable mask
`define I2IM_MASK_RST 13'h08ff

`endif

// File: src/i2im_flags.sv
// sticky raw interrupt flags, one per source
// assumes set and clear are one-cycle pulses on sys_clk
`timescale 1ns/10ps
`include "i2im_defs.svh"

module i2im_flags (
  input wire logic sys_clk, // register clock
  input wire logic reset, // async reset, active high
  input wire logic [`I2IM_NSRC-1:0] set, // event pulses
  input wire logic [`I2IM_NSRC-1:0] clr, // clear pulses
  output logic [`I2IM_NSRC-1:0] flags_r // sticky state
);

  //////////////////////////////////////////////////////////////////////
  // one flop per source; a set in the clear cycle wins
  genvar g;
  generate
    for (g = 0; g < `I2IM_NSRC; g = g + 1) begin : g_flag
      logic flag_nxt;
      assign flag_nxt = set[g] | (flags_r[g] & ~clr[g]); // [RQ11]
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          flags_r[g] <= 1'b0;
        end else begin
          flags_r[g] <= flag_nxt;
        end
      end
    end
  endgenerate

endmodule

// File: src/i2im_pkg.sv
// types shared by the interrupt mask stage
// assumes i2im_defs.svh is compiled alongside
package i2im_pkg;

  // one apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } i2im_apb_t;

  // decoded register target
  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_MASKED = 3'b001,
    REG_MASK = 3'b010,
    REG_RAW = 3'b011,
    REG_W1C = 3'b100,
    REG_CLR_ALL = 3'b101,
    REG_CLR_ONE = 3'b110
  } i2im_reg_t;

endpackage

// File: src/i2im_top.sv
// i2c interrupt mask stage: raw flags, enable mask, masked status, irq
// assumes an apb master on sys_clk and event pulses synchronous to it
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "i2im_defs.svh"

module i2im_top (
  input wire logic sys_clk, // 20 mhz register clock
  input wire logic reset, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [`I2IM_AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [`I2IM_NSRC-1:0] raw_event, // source event pulses
  output logic irq // combined interrupt level
);

  //////////////////////////////////////////////////////////////////////
  // declarations
  i2im_pkg::i2im_apb_t req;
  i2im_pkg::i2im_reg_t reg_sel;
  logic [`I2IM_NSRC-1:0] mask_r;
  logic [`I2IM_NSRC-1:0] raw_r;
  logic [`I2IM_NSRC-1:0] masked_w;
  logic [`I2IM_NSRC-1:0] clr_w;
  logic [`I2IM_NSRC-1:0] one_hot_w;
  logic [3:0] clr_idx;
  logic [`I2IM_AW-1:0] clr_ofs;
  logic setup_w;
  logic access_w;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] rdata_nxt;
  logic [31:0] prdata_r;
  logic pslverr_r;

  //////////////////////////////////////////////////////////////////////
  // bundle the apb request
  assign req.sel = psel;
  assign req.en = penable;
  assign req.wr = pwrite;
  assign req.addr = paddr;
  assign req.wdata = pwdata;

  // phase strobes; the slave answers with no wait state
  assign setup_w = req.sel & ~req.en;
  assign access_w = req.sel & req.en;
  assign pready = access_w;
  assign wr_acc = access_w & req.wr;
  assign rd_acc = access_w & ~req.wr;

  //////////////////////////////////////////////////////////////////////
  // address decode, aligned words only
  assign clr_ofs = req.addr - `I2IM_OFF_CLR_BASE;
  assign clr_idx = clr_ofs[5:2];

  always_comb begin
    reg_sel = i2im_pkg::REG_NONE;
    if (req.addr[1:0] == 2'h0) begin
      case (req.addr)
        `I2IM_OFF_MASKED: begin
          reg_sel = i2im_pkg::REG_MASKED;
        end
        `I2IM_OFF_MASK: begin
          reg_sel = i2im_pkg::REG_MASK; // [RQ2]
        end
        `I2IM_OFF_RAW: begin
          reg_sel = i2im_pkg::REG_RAW;
        end
        `I2IM_OFF_W1C: begin
          reg_sel = i2im_pkg::REG_W1C;
        end
        `I2IM_OFF_CLR_ALL: begin
          reg_sel = i2im_pkg::REG_CLR_ALL;
        end
        default: begin
          if (req.addr >= `I2IM_OFF_CLR_BASE && req.addr <= `I2IM_OFF_CLR_LAST) begin
            reg_sel = i2im_pkg::REG_CLR_ONE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // enable mask, read-write, per-bit reset values
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mask_r <= `I2IM_MASK_RST; // [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ8]
    end else if (wr_acc && reg_sel == i2im_pkg::REG_MASK) begin
      mask_r <= req.wdata[`I2IM_NSRC-1:0]; // [RQ9] upper bits dropped
    end
  end

  //////////////////////////////////////////////////////////////////////
  // clear sources: clear-on-read registers and write-one-to-clear
  always_comb begin
    one_hot_w = '0;
    one_hot_w[clr_idx] = 1'b1;
  end

  always_comb begin
    clr_w = '0;
    if (rd_acc && reg_sel == i2im_pkg::REG_CLR_ALL) begin
      clr_w = '1; // [RQ10]
    end else if (rd_acc && reg_sel == i2im_pkg::REG_CLR_ONE) begin
      clr_w = one_hot_w; // [RQ10]
    end else if (wr_acc && reg_sel == i2im_pkg::REG_W1C) begin
      clr_w = req.wdata[`I2IM_NSRC-1:0];
    end
  end

  // sticky raw flags
  i2im_flags u_flags (
    .sys_clk(sys_clk),
    .reset(reset),
    .set(raw_event),
    .clr(clr_w),
    .flags_r(raw_r)
  );

  //////////////////////////////////////////////////////////////////////
  // gating and the combined request
  assign masked_w = raw_r & mask_r; // [RQ1] [RQ2] [RQ10]
  assign irq = |masked_w; // [RQ12]

  //////////////////////////////////////////////////////////////////////
  // read mux, evaluated in the setup cycle
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (reg_sel)
      i2im_pkg::REG_MASKED: begin
        rdata_nxt[`I2IM_NSRC-1:0] = masked_w; // [RQ10]
      end
      i2im_pkg::REG_MASK: begin
        rdata_nxt[`I2IM_NSRC-1:0] = mask_r; // [RQ9] upper bits zero
      end
      i2im_pkg::REG_RAW: begin
        rdata_nxt[`I2IM_NSRC-1:0] = raw_r; // [RQ11]
      end
      i2im_pkg::REG_CLR_ALL: begin
        rdata_nxt[0] = |raw_r;
      end
      i2im_pkg::REG_CLR_ONE: begin
        rdata_nxt[0] = |(raw_r & one_hot_w);
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // read data and error captured at setup, shown through access
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_w) begin
      prdata_r <= req.wr ? 32'h0000_0000 : rdata_nxt;
      pslverr_r <= (reg_sel == i2im_pkg::REG_NONE);
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r & access_w;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // reset values of the enable mask, one check per group, one shared check for bits 7 to 0
  restart_reset_a: assert property ($past(reset) |-> !mask_r[`I2IM_BIT_RESTART] && irq == 1'b0) // [RQ3]
    else $error("restart enable not zero after reset");
  gencall_reset_a: assert property ($past(reset) |-> mask_r[`I2IM_BIT_GEN_CALL]) // [RQ4]
    else $error("general call enable not one after reset");
  bus_reset_a: assert property ($past(reset) |-> mask_r[10:8] == 3'h0) // [RQ5]
    else $error("start stop activity enables not zero after reset");
  data_reset_a: assert property ($past(reset) |-> mask_r[7:0] == 8'hff) // [RQ6] [RQ7] [RQ8]
    else $error("low enables not one after reset");

  // a mask write lands on the next edge and reserved bits read zero
  mask_write_a: assert property (
    wr_acc && req.addr == `I2IM_OFF_MASK |=> mask_r == $past(pwdata[12:0])) // [RQ2]
    else $error("mask write not stored");
  mask_reserved_a: assert property (
    rd_acc && req.addr == `I2IM_OFF_MASK |-> prdata[31:13] == 19'h0) // [RQ9]
    else $error("reserved mask bits not zero");

  // masked read matches raw gated by mask at setup
  masked_read_a: assert property (
    rd_acc && req.addr == `I2IM_OFF_MASKED
    |-> prdata[12:0] == ($past(raw_r) & $past(mask_r))) // [RQ10]
    else $error("masked status read wrong");
  clear_all_a: assert property (
    rd_acc && req.addr == `I2IM_OFF_CLR_ALL && raw_event == 13'h0 |=> irq == 1'b0) // [RQ10]
    else $error("clear read left an interrupt");

  // raw flags catch every event and ignore the mask
  raw_catch_a: assert property (
    raw_event != 13'h0 |=> (raw_r & $past(raw_event)) == $past(raw_event)) // [RQ11]
    else $error("raw flag missed an event");
  raw_read_a: assert property (
    rd_acc && req.addr == `I2IM_OFF_RAW |-> prdata[12:0] == $past(raw_r)) // [RQ11]
    else $error("raw status read wrong");

  // zero mask silences the request
  mask_silence_a: assert property (
    wr_acc && req.addr == `I2IM_OFF_MASK && pwdata[12:0] == 13'h0 |=> !irq) // [RQ1] [RQ12]
    else $error("irq with all sources suppressed");
  irq_source_a: assert property (
    raw_event != 13'h0 && (raw_event & mask_r) == raw_event |=> irq [*2]) // [RQ12]
    else $error("enabled event did not raise irq");

  //////////////////////////////////////////////////////////////////////
  // bus answer checks: zero wait states, errors only on refused addresses

  // every access phase is answered at once
  pready_nowait_a: assert property ( // [RQ2]
    psel && penable |-> pready)
    else $error("access phase without ready");

  // ready never shows outside a selected transfer
  pready_idle_a: assert property ( // [RQ2]
    !psel |-> !pready)
    else $error("ready while not selected");

  // the error flag stands only in an access phase
  err_access_a: assert property ( // [RQ2]
    pslverr |-> psel && penable)
    else $error("error outside access phase");

  // a misaligned word address is refused
  err_misalign_a: assert property ( // [RQ2]
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");

  // the enable mask itself is never refused
  err_mask_a: assert property ( // [RQ2]
    psel && penable && paddr == `I2IM_OFF_MASK |-> !pslverr)
    else $error("mask access refused");

  // addresses above the clear block are refused
  err_high_a: assert property ( // [RQ2]
    psel && penable && paddr > `I2IM_OFF_CLR_LAST |-> pslverr)
    else $error("unmapped access not refused");

  // the last per-source clear register is mapped
  err_clr_ok_a: assert property ( // [RQ10]
    psel && penable && paddr == `I2IM_OFF_CLR_LAST |-> !pslverr)
    else $error("last clear register refused");

  // a refused access returns zero data
  rdata_err_a: assert property ( // [RQ2]
    pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");

  // write cycles show zero read data
  rdata_write_a: assert property ( // [RQ9]
    psel && penable && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data during a write");

  // read data only moves at a setup edge
  rdata_idle_a: assert property ( // [RQ10]
    !(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");

  //////////////////////////////////////////////////////////////////////
  // register state checks

  // the mask only moves on a write to its own offset
  mask_hold_a: assert property ( // [RQ2]
    !(wr_acc && paddr == `I2IM_OFF_MASK) |=> $stable(mask_r))
    else $error("mask changed without a write");

  // a mask read returns the stored enables
  mask_read_a: assert property ( // [RQ2]
    rd_acc && paddr == `I2IM_OFF_MASK |-> prdata[12:0] == $past(mask_r))
    else $error("mask read wrong");

  // writes to the raw status leave the flags alone
  raw_ignore_a: assert property ( // [RQ11]
    wr_acc && paddr == `I2IM_OFF_RAW && raw_event == 13'h0 |=> raw_r == $past(raw_r))
    else $error("raw status write took effect");

  // raw status reads keep the reserved bits zero
  raw_upper_a: assert property ( // [RQ11]
    rd_acc && paddr == `I2IM_OFF_RAW |-> prdata[31:13] == 19'h0)
    else $error("raw reserved bits not zero");

  // writes to the masked status do not touch the mask
  masked_ignore_a: assert property ( // [RQ10]
    wr_acc && paddr == `I2IM_OFF_MASKED |=> $stable(mask_r))
    else $error("masked status write changed mask");

  // write-one-to-clear drops every written flag without a new event
  w1c_clear_a: assert property ( // [RQ10]
    wr_acc && paddr == `I2IM_OFF_W1C
    |=> (raw_r & $past(pwdata[12:0]) & ~$past(raw_event)) == 13'h0)
    else $error("write-one-to-clear left a flag");

  // write-one-to-clear keeps the flags not written
  w1c_keep_a: assert property ( // [RQ11]
    wr_acc && paddr == `I2IM_OFF_W1C
    |=> (raw_r & ~$past(pwdata[12:0]))
        == (($past(raw_r) | $past(raw_event)) & ~$past(pwdata[12:0])))
    else $error("write-one-to-clear dropped another flag");

  // with no access and no event the flags stand still
  flags_quiet_a: assert property ( // [RQ11]
    !access_w && raw_event == 13'h0 |=> $stable(raw_r))
    else $error("flags moved with no cause");

  // with no access and no event the request stands still
  irq_quiet_a: assert property ( // [RQ12]
    !access_w && raw_event == 13'h0 |=> $stable(irq))
    else $error("irq moved with no cause");

  // the request agrees with the masked status that was read
  irq_read_a: assert property ( // [RQ12]
    rd_acc && paddr == `I2IM_OFF_MASKED |-> $past(irq) == (prdata[12:0] != 13'h0))
    else $error("irq disagrees with masked status");

  // the clear-all read reports whether any flag was set
  clr_all_val_a: assert property ( // [RQ10]
    rd_acc && paddr == `I2IM_OFF_CLR_ALL |-> prdata == {31'h0, $past(raw_r) != 13'h0})
    else $error("clear-all read value wrong");

  //////////////////////////////////////////////////////////////////////
  // per-source checks of gating, clearing and set priority
  genvar s;
  generate
    for (s = 0; s < `I2IM_NSRC; s = s + 1) begin : g_src_chk

      // a zero enable hides its source in the masked status
      gate_off_a: assert property ( // [RQ1]
        rd_acc && paddr == `I2IM_OFF_MASKED && !$past(mask_r[s]) |-> !prdata[s])
        else $error("suppressed source shown");

      // a one enable passes its source unchanged
      gate_on_a: assert property ( // [RQ1] [RQ2]
        rd_acc && paddr == `I2IM_OFF_MASKED && $past(mask_r[s]) |-> prdata[s] == $past(raw_r[s]))
        else $error("enabled source not shown");

      // reading its own clear register drops the flag
      clear_one_a: assert property ( // [RQ10]
        rd_acc && paddr == 12'(`I2IM_OFF_CLR_BASE + 4 * s) && !raw_event[s] |=> !raw_r[s])
        else $error("clear read left its flag");

      // the clear read returns the flag before the clear
      clear_val_a: assert property ( // [RQ10]
        rd_acc && paddr == 12'(`I2IM_OFF_CLR_BASE + 4 * s)
        |-> prdata == {31'h0, $past(raw_r[s])})
        else $error("clear read value wrong");

      // an event always sets its flag, even against a clear
      set_wins_a: assert property ( // [RQ11]
        raw_event[s] |=> raw_r[s])
        else $error("event lost against a clear");
    end
  endgenerate

endmodule
